// ### core/mdcfg_top.sv
`timescale 1ns/1ps
`include "mdcfg_regs.svh"
module mdcfg_top (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register access from the serial interface controller.
  input wire logic wr_strobe,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // Bridge input pins.
  input wire logic [1:0] bridge_input_pins,
  // Events from the detection engines.
  input wire mdcfg_pkg::mdcfg_events_t events,
  // Configuration toward the engines.
  output mdcfg_pkg::mdcfg_cfg_t cfg,
  output mdcfg_pkg::mdcfg_bridge_t bridge,
  output logic fault_clear,
  output logic fault_pin_n
);

  mdcfg_pkg::mdcfg_state_t state;
  mdcfg_pkg::mdcfg_state_t next_state;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_stable;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input mdcfg_pkg::mdcfg_state_t s);
    case (a)
      `MDCFG_OFS_FAULT_CTRL: read_mux = 8'h00;
      `MDCFG_OFS_INRUSH_LO: read_mux = s.inrush_lo;
      `MDCFG_OFS_INRUSH_HI: read_mux = s.inrush_hi;
      `MDCFG_OFS_MODE_TIMING: read_mux = s.mode_timing;
      `MDCFG_OFS_REPORT_BRIDGE: read_mux = s.report_bridge;
      `MDCFG_OFS_REG_SCHEME: read_mux = s.reg_scheme;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  always_comb begin
    next_state = state;
    next_state.fault_clear = 1'b0;
    if (wr_strobe) begin
      case (addr)
        `MDCFG_OFS_FAULT_CTRL: next_state.fault_clear = wr_data[`MDCFG_BIT_FAULT_CLEAR];
        `MDCFG_OFS_INRUSH_LO: next_state.inrush_lo = wr_data;
        `MDCFG_OFS_INRUSH_HI: next_state.inrush_hi = wr_data;
        `MDCFG_OFS_MODE_TIMING: next_state.mode_timing = wr_data;
        `MDCFG_OFS_REPORT_BRIDGE: next_state.report_bridge = wr_data;
        `MDCFG_OFS_REG_SCHEME: next_state.reg_scheme = wr_data;
        default: next_state.rd_data = state.rd_data;
      endcase
    end
    next_state.rd_data = read_mux(addr, next_state);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state.inrush_lo <= `MDCFG_RST_INRUSH_LO;
      state.inrush_hi <= `MDCFG_RST_INRUSH_HI;
      state.mode_timing <= `MDCFG_RST_MODE_TIMING;
      state.report_bridge <= `MDCFG_RST_REPORT_BRIDGE;
      state.reg_scheme <= `MDCFG_RST_REG_SCHEME;
      state.fault_clear <= 1'b0;
      state.rd_data <= 8'h00;
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      pin_stable <= 2'h0;
    end else begin
      state <= next_state;
      pin_s1 <= bridge_input_pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_stable[i] <= pin_s3[i];
        end
      end
    end
  end

  logic [7:0] mt;
  logic [7:0] rb;
  logic cycle_mode;
  logic ripple_flag;
  assign mt = state.mode_timing;
  assign rb = state.report_bridge;
  assign rd_data = state.rd_data;
  assign fault_clear = state.fault_clear;

  always_comb begin
    cfg.current_reg_behavior = mt[`MDCFG_POS_CURBEH_HI:`MDCFG_POS_CURBEH_LO];
    cfg.stall_response_select = mt[`MDCFG_BIT_STALL_RESP];
    cfg.internal_ref_500mv = mt[`MDCFG_BIT_INT_REF];
    cfg.sense_blank_cycles = mt[`MDCFG_BIT_BLANK] ? 6'(`MDCFG_BLANK_SHORT_CYC)
                                                 : 6'(`MDCFG_BLANK_LONG_CYC);
    cfg.deglitch_cycles = mt[`MDCFG_BIT_DEGLITCH] ? 7'(`MDCFG_DEG_SHORT_CYC)
                                                 : 7'(`MDCFG_DEG_LONG_CYC);
    cfg.overcurrent_response_select = mt[`MDCFG_BIT_OCP_RESP];
    cfg.overtemp_response_select = mt[`MDCFG_BIT_OTP_RESP];
    cfg.ripple_report_select = rb[`MDCFG_POS_RIPPLE_HI:`MDCFG_POS_RIPPLE_LO];
    cfg.reg_scheme = state.reg_scheme[`MDCFG_POS_SCHEME_HI:`MDCFG_POS_SCHEME_LO];
    cfg.phase_enable_mode = ~rb[`MDCFG_BIT_INPUT_MODE];
    cfg.inrush_blank_time = {state.inrush_hi, state.inrush_lo};
  end

  always_comb begin
    if (rb[`MDCFG_BIT_BRIDGE_SRC]) begin
      bridge.in_one = rb[`MDCFG_BIT_REG_IN1];
      bridge.in_two = rb[`MDCFG_BIT_REG_IN2];
    end else begin
      bridge.in_one = pin_stable[1];
      bridge.in_two = pin_stable[0];
    end
  end

  assign cycle_mode = (cfg.reg_scheme == `MDCFG_SCHEME_CYCLE);
  assign ripple_flag = (cfg.ripple_report_select != 2'h0) && events.ripple_over;
  assign fault_pin_n = ~((rb[`MDCFG_BIT_STALL_REPORT_ENABLE] && events.stall_detected)
                       || (cycle_mode && rb[`MDCFG_BIT_CYCLE_REP] && events.cycle_regulating)
                       || ripple_flag);

endmodule : mdcfg_top

// ### core/mdcfg_regs.svh
`ifndef MDCFG_REGS_SVH
`define MDCFG_REGS_SVH

// Register offsets on the 8-bit register address space.
`define MDCFG_OFS_FAULT_CTRL 8'h09
`define MDCFG_OFS_INRUSH_LO 8'h0a
`define MDCFG_OFS_INRUSH_HI 8'h0b
`define MDCFG_OFS_MODE_TIMING 8'h0c
`define MDCFG_OFS_REPORT_BRIDGE 8'h0d
`define MDCFG_OFS_REG_SCHEME 8'h0e

// Reset values.
`define MDCFG_RST_INRUSH_LO 8'h00
`define MDCFG_RST_INRUSH_HI 8'h00
`define MDCFG_RST_MODE_TIMING 8'h63
`define MDCFG_RST_REPORT_BRIDGE 8'h38
`define MDCFG_RST_REG_SCHEME 8'h00

// Field positions in the fault control register.
`define MDCFG_BIT_FAULT_CLEAR 1

// Field positions in the regulation scheme register.
`define MDCFG_POS_SCHEME_LO 3
`define MDCFG_POS_SCHEME_HI 4
`define MDCFG_SCHEME_CYCLE 2'h1

// Field positions in the mode and timing register.
`define MDCFG_POS_CURBEH_LO 6
`define MDCFG_POS_CURBEH_HI 7
`define MDCFG_BIT_STALL_RESP 5
`define MDCFG_BIT_INT_REF 4
`define MDCFG_BIT_BLANK 3
`define MDCFG_BIT_DEGLITCH 2
`define MDCFG_BIT_OCP_RESP 1
`define MDCFG_BIT_OTP_RESP 0

// Field positions in the report and bridge register.
`define MDCFG_POS_RIPPLE_LO 6
`define MDCFG_POS_RIPPLE_HI 7
`define MDCFG_BIT_STALL_REPORT_ENABLE 5
`define MDCFG_BIT_CYCLE_REP 4
`define MDCFG_BIT_INPUT_MODE 3
`define MDCFG_BIT_BRIDGE_SRC 2
`define MDCFG_BIT_REG_IN1 1
`define MDCFG_BIT_REG_IN2 0

// Timing figures in nanoseconds and their cycle counts at 25 MHz.
`define MDCFG_CLK_NS 40
`define MDCFG_BLANK_LONG_NS 1800
`define MDCFG_BLANK_SHORT_NS 1000
`define MDCFG_DEG_LONG_NS 2000
`define MDCFG_DEG_SHORT_NS 1000
`define MDCFG_BLANK_LONG_CYC ((`MDCFG_BLANK_LONG_NS + `MDCFG_CLK_NS - 1) / `MDCFG_CLK_NS)
`define MDCFG_BLANK_SHORT_CYC ((`MDCFG_BLANK_SHORT_NS + `MDCFG_CLK_NS - 1) / `MDCFG_CLK_NS)
`define MDCFG_DEG_LONG_CYC ((`MDCFG_DEG_LONG_NS + `MDCFG_CLK_NS - 1) / `MDCFG_CLK_NS)
`define MDCFG_DEG_SHORT_CYC ((`MDCFG_DEG_SHORT_NS + `MDCFG_CLK_NS - 1) / `MDCFG_CLK_NS)

`endif

// ### core/mdcfg_pkg.sv
package mdcfg_pkg;

  typedef struct packed {
    logic [7:0] inrush_lo;
    logic [7:0] inrush_hi;
    logic [7:0] mode_timing;
    logic [7:0] report_bridge;
    logic [7:0] reg_scheme;
    logic fault_clear;
    logic [7:0] rd_data;
  } mdcfg_state_t;

  typedef struct packed {
    logic [1:0] current_reg_behavior;
    logic stall_response_select;
    logic internal_ref_500mv;
    logic [5:0] sense_blank_cycles;
    logic [6:0] deglitch_cycles;
    logic overcurrent_response_select;
    logic overtemp_response_select;
    logic [1:0] ripple_report_select;
    logic [1:0] reg_scheme;
    logic phase_enable_mode;
    logic [15:0] inrush_blank_time;
  } mdcfg_cfg_t;

  typedef struct packed {
    logic in_one;
    logic in_two;
  } mdcfg_bridge_t;

  typedef struct packed {
    logic stall_detected;
    logic cycle_regulating;
    logic ripple_over;
  } mdcfg_events_t;

endpackage : mdcfg_pkg

// ### tb/mdcfg_chk.sv
`timescale 1ns/1ps
module mdcfg_chk (
  // Clock, reset and register access.
  input wire logic clock,
  input wire logic rst,
  input wire logic wr_strobe,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  // Decoded outputs.
  input wire mdcfg_pkg::mdcfg_cfg_t cfg,
  input wire mdcfg_pkg::mdcfg_bridge_t bridge,
  input wire logic fault_clear
);
  logic [7:0] wd_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  always_ff @(posedge clock) wd_q <= wr_data;
  sequence wr_at(logic [7:0] a);
    wr_strobe && addr == a;
  endsequence
  clear_pulse_a: assert property (wr_at(8'h09) ##0 wr_data[1] |=> fault_clear) else $error("no clear pulse");
  clear_cause_a: assert property (fault_clear |-> $past(wr_strobe) && $past(addr) == 8'h09 &&
    ($past(wr_data) & 8'h02) != 8'h00) else $error("stray clear pulse");
  read_back_a: assert property (wr_at(8'h0d) |=> rd_data == wd_q) else $error("read back wrong");
  mode_bits_a: assert property (wr_at(8'h0c) |=> {cfg.current_reg_behavior, cfg.stall_response_select,
    cfg.internal_ref_500mv} == wd_q[7:4]) else $error("mode fields wrong");
  blank_time_a: assert property (wr_at(8'h0c) |=> cfg.sense_blank_cycles == (wd_q[3] ? 6'h19 : 6'h2d))
    else $error("blank time wrong");
  deglitch_time_a: assert property (wr_at(8'h0c) |=> cfg.deglitch_cycles == (wd_q[2] ? 7'h19 : 7'h32))
    else $error("deglitch wrong");
  fault_resp_a: assert property (wr_at(8'h0c) |=> {cfg.overcurrent_response_select,
    cfg.overtemp_response_select} == wd_q[1:0]) else $error("response select wrong");
  report_sel_a: assert property (wr_at(8'h0d) |=> cfg.ripple_report_select == wd_q[7:6] &&
    cfg.phase_enable_mode == !wd_q[3]) else $error("report fields wrong");
  bridge_reg_a: assert property (wr_at(8'h0d) ##0 wr_data[2] |=> {bridge.in_one, bridge.in_two} == wd_q[1:0])
    else $error("bridge bits wrong");
  inrush_hi_a: assert property (wr_at(8'h0b) |=> cfg.inrush_blank_time[15:8] == wd_q) else $error("inrush hi");
endmodule : mdcfg_chk
bind mdcfg_top mdcfg_chk i_chk (.clock(clock), .rst(rst), .wr_strobe(wr_strobe), .addr(addr), .wr_data(wr_data),
  .rd_data(rd_data), .cfg(cfg), .bridge(bridge), .fault_clear(fault_clear));

// ### tb/mdcfg_host.sv
`timescale 1ns/1ps
module mdcfg_host (
  // Clock and read data.
  input wire logic clock,
  input wire logic [7:0] rd_data,
  // Register access.
  output logic wr_strobe,
  output logic [7:0] addr,
  output logic [7:0] wr_data
);
  initial begin
    wr_strobe = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_strobe <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wr_data <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    @(posedge clock);
    #1 d = rd_data;
  endtask : read_reg
endmodule : mdcfg_host

// ### tb/tb_motor_driver_config_regs.sv
`timescale 1ns/1ps
module tb_motor_driver_config_regs;
  logic clock, rst, wr_strobe, fault_clear, fault_pin_n;
  logic [7:0] addr, wr_data, rd_data;
  logic [1:0] pins;
  mdcfg_pkg::mdcfg_events_t ev;
  mdcfg_pkg::mdcfg_cfg_t cfg;
  mdcfg_pkg::mdcfg_bridge_t br;
  int n_errors = 0;
  int num_checks = 0;
  mdcfg_top i_dut (.clock(clock), .rst(rst), .wr_strobe(wr_strobe), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .bridge_input_pins(pins), .events(ev), .cfg(cfg), .bridge(br),
    .fault_clear(fault_clear), .fault_pin_n(fault_pin_n));
  mdcfg_host i_host (.clock(clock), .rd_data(rd_data), .wr_strobe(wr_strobe), .addr(addr), .wr_data(wr_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read_reg(a, d);
    chk(d, exp);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
    #1;
  endtask : wr
  task automatic test_done;
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic reset_values;
    rd(8'h0c, 8'h63);
    rd(8'h0d, 8'h38);
    rd(8'h0b, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h20, 8'h00);
  endtask : reset_values
  task automatic inrush_time;
    wr(8'h0b, 8'ha5);
    wr(8'h0a, 8'h3c);
    chk(cfg.inrush_blank_time, 16'ha53c);
  endtask : inrush_time
  task automatic mode_timing;
    mode_one(8'h08);
    mode_one(8'h04);
    mode_one(8'h13);
    mode_one(8'hc2);
  endtask : mode_timing
  task automatic mode_one(input logic [7:0] m);
    wr(8'h0c, m);
    chk(cfg.sense_blank_cycles, m[3] ? 16'h0019 : 16'h002d);
    chk(cfg.deglitch_cycles, m[2] ? 16'h0019 : 16'h0032);
    chk({cfg.current_reg_behavior, cfg.stall_response_select, cfg.internal_ref_500mv}, m[7:4]);
    chk({cfg.overcurrent_response_select, cfg.overtemp_response_select}, m[1:0]);
  endtask : mode_one
  task automatic bridge_source;
    @(posedge clock) pins <= 2'b10;
    repeat (5) @(posedge clock);
    #1 chk(br, 2'b10);
    wr(8'h0d, 8'h07);
    chk(br, 2'b11);
    chk(cfg.phase_enable_mode, 1'b1);
    wr(8'h0d, 8'h0b);
    chk(br, 2'b10);
    chk(cfg.phase_enable_mode, 1'b0);
  endtask : bridge_source
  task automatic fault_report;
    @(posedge clock) ev <= 3'b100;
    wr(8'h0d, 8'h20);
    chk(fault_pin_n, 1'b0);
    wr(8'h0d, 8'h00);
    chk(fault_pin_n, 1'b1);
    @(posedge clock) ev <= 3'b010;
    wr(8'h0e, 8'h08);
    wr(8'h0d, 8'h10);
    chk(fault_pin_n, 1'b0);
    wr(8'h0e, 8'h00);
    chk(fault_pin_n, 1'b1);
    @(posedge clock) ev <= 3'b001;
    wr(8'h0d, 8'h40);
    chk(fault_pin_n, 1'b0);
    i_host.write_reg(8'h09, 8'h02);
    #1 chk(fault_clear, 1'b1);
    @(posedge clock);
    #1 chk(fault_clear, 1'b0);
  endtask : fault_report
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    pins = 2'b00;
    ev = 3'b000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    reset_values();
    inrush_time();
    mode_timing();
    bridge_source();
    fault_report();
    test_done();
  end
endmodule : tb_motor_driver_config_regs
